// ---- adcc_regs.vh ----
/*
 Register offsets, field positions, reset values and timing counts
 of the converter control block. Assumes a 25 MHz APB clock.
*/
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH

`define ADCC_IDX_CONV      12'h01F
`define ADCC_IDX_FMT       12'h09F
`define ADCC_OFF_CONV      (`ADCC_IDX_CONV << 2)
`define ADCC_OFF_FMT       (`ADCC_IDX_FMT << 2)
`define ADCC_OFF_RESH      12'h078
`define ADCC_OFF_RESL      12'h278
`define ADCC_OFF_IRQ_STAT  12'h300
`define ADCC_OFF_IRQ_CLR   12'h304
`define ADCC_OFF_IRQ_EN    12'h308
`define ADCC_OFF_GIE       12'h30C

`define ADCC_FMT_JUSTIFY   7
`define ADCC_FMT_HALVE     6
`define ADCC_FMT_PCFG_MSB  3
`define ADCC_FMT_MASK      8'hCF
`define ADCC_FMT_RST       8'h00

`define ADCC_CONV_CLK_MSB  7
`define ADCC_CONV_CHS_MSB  5
`define ADCC_CONV_GO       2
`define ADCC_CONV_ON       0
`define ADCC_CONV_MASK     8'hFD
`define ADCC_CONV_RST      8'h00

`define ADCC_CONV_TAD      4'h9
`define ADCC_GAP_TAD       2'h2
`define ADCC_RC_TAD_NS     4000
`define ADCC_CLK_NS        40
`define ADCC_RC_CYC        ((`ADCC_RC_TAD_NS) / (`ADCC_CLK_NS))

`endif

// ---- adcc_sar.v ----
/*
 Ten-bit successive approximation engine, one bit per bit period.
 Assumes a comparator input that settles within one bit period.
*/
`timescale 1ns/1ps
module adcc_sar (
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // Control
    input  wire       tad_tick,
    input  wire       start,
    input  wire       abort,
    input  wire       cmp_above,
    // Result
    output reg  [9:0] trial_r,
    output reg        busy_r,
    output reg        done_r
);
    reg [3:0] bit_r;
    reg       fresh_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trial_r <= 10'h000;
            busy_r  <= 1'b0;
            done_r  <= 1'b0;
            bit_r   <= 4'h0;
            fresh_r <= 1'b0;
        end else begin
            done_r  <= 1'b0;
            fresh_r <= 1'b0;
            if (abort) begin
                busy_r <= 1'b0;
            end else if (start && !busy_r) begin
                busy_r  <= 1'b1;
                bit_r   <= 4'h9;
                trial_r <= 10'h200;
                fresh_r <= 1'b1;
            // First tick after start would test a stale trial code
            end else if (busy_r && tad_tick && !fresh_r) begin
                // Keep bit under test only if input is above trial
                if (!cmp_above) begin
                    trial_r[bit_r] <= 1'b0;
                end
                if (bit_r == 4'h0) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end else begin
                    trial_r[bit_r - 4'h1] <= 1'b1;
                    bit_r <= bit_r - 4'h1;
                end
            end
        end
    end
endmodule

// ---- adcc_top.v ----
/*
 Converter control: APB registers, bit-period clock, conversion
 sequencing, pin configuration and interrupt. Assumes the analog
 front end offers a comparator against the trial code.
*/
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "adcc_regs.vh"
module adcc_top (
    // APB
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Analog front end
    input  wire        cmp_above,
    output reg  [9:0]  dac_code,
    output reg  [2:0]  channel_sel,
    output reg         hold_connect,
    output reg         converter_power,
    // Pin configuration
    output reg  [4:0]  analog_pin_en,
    output reg         vref_pos_pin,
    output reg         vref_neg_pin,
    // Interrupt
    output reg         irq
);
    localparam ST_IDLE = 3'b001;
    localparam ST_CONV = 3'b010;
    localparam ST_GAP  = 3'b100;

    reg  [7:0] fmt_r;
    reg  [7:0] conv_r;
    reg  [7:0] resh_r;
    reg  [7:0] resl_r;
    reg        flag_r;
    reg        irq_en_r;
    reg        gie_r;
    reg  [2:0] state_r;
    reg  [5:0] div_r;
    reg  [7:0] rc_r;
    reg  [1:0] gap_r;
    reg        tad_tick;
    reg        go_set;
    reg        sar_start;
    wire [9:0] trial;
    wire       sar_busy;
    wire       sar_done;

    wire wr_acc = psel && penable && pwrite;
    wire rd_acc = psel && penable && !pwrite;
    wire on     = conv_r[`ADCC_CONV_ON];

    // Analog pin mask and reference use for a pin code
    function [6:0] pin_map;
        input [3:0] code;
        begin
            case (code)
                4'h0, 4'h2, 4'h9: pin_map = 7'b11111_00;
                4'h1, 4'h3, 4'hA: pin_map = 7'b10111_10;
                4'h4: pin_map = 7'b01011_00;
                4'h5: pin_map = 7'b00011_10;
                4'h6, 4'h7: pin_map = 7'b00000_00;
                4'h8, 4'hB, 4'hC: pin_map = 7'b10011_11;
                4'hD: pin_map = 7'b00011_11;
                4'hE: pin_map = 7'b00001_00;
                4'hF: pin_map = 7'b00001_11;
                default: pin_map = 7'b11111_00;
            endcase
        end
    endfunction

    // System clock divide for the select code
    function [6:0] div_ratio;
        input [1:0] sel;
        input       halve;
        begin
            case (sel)
                2'b00: div_ratio = halve ? 7'd4 : 7'd2;
                2'b01: div_ratio = halve ? 7'd16 : 7'd8;
                2'b10: div_ratio = halve ? 7'd64 : 7'd32;
                default: div_ratio = 7'd64;
            endcase
        end
    endfunction

    wire [1:0] clk_sel = conv_r[`ADCC_CONV_CLK_MSB -: 2];
    wire [6:0] ratio = div_ratio(clk_sel, fmt_r[`ADCC_FMT_HALVE]);
    wire       use_rc = (clk_sel == 2'b11);
    wire       sys_tick = ({1'b0, div_r} == ratio - 7'd1);
    wire [31:0] rc_last = `ADCC_RC_CYC - 1;
    wire       rc_tick = ({24'h000000, rc_r} == rc_last);

    // Bit-period generator, idle while converter is off
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r    <= 6'h00;
            rc_r     <= 8'h00;
            tad_tick <= 1'b0;
        end else if (!on) begin
            div_r    <= 6'h00;
            rc_r     <= 8'h00;
            tad_tick <= 1'b0;
        end else begin
            div_r    <= sys_tick ? 6'h00 : div_r + 6'h01;
            rc_r     <= rc_tick ? 8'h00 : rc_r + 8'h01;
            tad_tick <= use_rc ? rc_tick : sys_tick;
        end
    end

    adcc_sar u_sar (
        .pclk      (pclk),
        .presetn   (presetn),
        .tad_tick  (tad_tick),
        .start     (sar_start),
        .abort     (!on),
        .cmp_above (cmp_above),
        .trial_r   (trial),
        .busy_r    (sar_busy),
        .done_r    (sar_done)
    );

    // Sequencer: convert, then a gap of two bit periods
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= ST_IDLE;
            gap_r     <= 2'h0;
            sar_start <= 1'b0;
        end else begin
            sar_start <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (on && go_set) begin
                        sar_start <= 1'b1;
                        state_r   <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (!on) begin
                        state_r <= ST_IDLE;
                    end else if (sar_done) begin
                        gap_r   <= 2'h0;
                        state_r <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (!on) begin
                        state_r <= ST_IDLE;
                    end else if (tad_tick) begin
                        if (gap_r == `ADCC_GAP_TAD - 2'h1) begin
                            state_r <= ST_IDLE;
                        end
                        gap_r <= gap_r + 2'h1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Start request seen once bit is set and engine idle
    always @* begin
        go_set = conv_r[`ADCC_CONV_GO] && state_r == ST_IDLE && !sar_busy;
    end

    // Registers, completion effects and sticky flag
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt_r    <= `ADCC_FMT_RST;
            conv_r   <= `ADCC_CONV_RST;
            resh_r   <= 8'h00;
            resl_r   <= 8'h00;
            flag_r   <= 1'b0;
            irq_en_r <= 1'b0;
            gie_r    <= 1'b0;
        end else begin
            if (wr_acc) begin
                case (paddr)
                    `ADCC_OFF_FMT:
                        fmt_r <= pwdata[7:0] & `ADCC_FMT_MASK;
                    `ADCC_OFF_CONV:
                        conv_r <= pwdata[7:0] & `ADCC_CONV_MASK;
                    `ADCC_OFF_RESH: resh_r <= pwdata[7:0];
                    `ADCC_OFF_RESL: resl_r <= pwdata[7:0];
                    `ADCC_OFF_IRQ_EN: irq_en_r <= pwdata[0];
                    `ADCC_OFF_GIE: gie_r <= pwdata[0];
                    default: ;
                endcase
            end
            if (wr_acc && paddr == `ADCC_OFF_IRQ_CLR && pwdata[0]) begin
                flag_r <= 1'b0;
            end
            // Start bit cannot stay set while converter is off
            if (!on && !(wr_acc && paddr == `ADCC_OFF_CONV)) begin
                conv_r[`ADCC_CONV_GO] <= 1'b0;
            end
            // Completion wins over a same-cycle software write
            if (sar_done && state_r == ST_CONV && on) begin
                conv_r[`ADCC_CONV_GO] <= 1'b0;
                flag_r <= 1'b1;
                if (fmt_r[`ADCC_FMT_JUSTIFY]) begin
                    resh_r <= {6'h00, trial[9:8]};
                    resl_r <= trial[7:0];
                end else begin
                    resh_r <= trial[9:2];
                    resl_r <= {trial[1:0], 6'h00};
                end
            end
        end
    end

    // APB read path and always-ready answer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `ADCC_OFF_FMT: prdata <= {24'h0, fmt_r};
                    `ADCC_OFF_CONV: prdata <= {24'h0, conv_r};
                    `ADCC_OFF_RESH: prdata <= {24'h0, resh_r};
                    `ADCC_OFF_RESL: prdata <= {24'h0, resl_r};
                    `ADCC_OFF_IRQ_STAT: prdata <= {31'h0, flag_r};
                    `ADCC_OFF_IRQ_EN: prdata <= {31'h0, irq_en_r};
                    `ADCC_OFF_GIE: prdata <= {31'h0, gie_r};
                    default: prdata <= 32'h0000_0000;
                endcase
            end else if (!rd_acc) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Front-end outputs, all registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_code        <= 10'h000;
            channel_sel     <= 3'h0;
            hold_connect    <= 1'b0;
            converter_power <= 1'b0;
            analog_pin_en   <= 5'h1F;
            vref_pos_pin    <= 1'b0;
            vref_neg_pin    <= 1'b0;
            irq             <= 1'b0;
        end else begin
            dac_code <= trial;
            // Codes above 100 fall back to input 0
            channel_sel <= (conv_r[`ADCC_CONV_CHS_MSB -: 3] > 3'h4) ?
                           3'h0 : conv_r[`ADCC_CONV_CHS_MSB -: 3];
            // Sampling only while idle with converter on, from power-on or gap end to conversion start
            hold_connect <= on && state_r == ST_IDLE && !go_set;
            converter_power <= on;
            {analog_pin_en, vref_pos_pin, vref_neg_pin} <=
                pin_map(fmt_r[`ADCC_FMT_PCFG_MSB:0]);
            irq <= flag_r && irq_en_r && gie_r;
        end
    end
endmodule

// ---- adcc_top_props.sv ----
/*
 Checker for adcc_top: register, pin and interrupt relations.
 Assumes zero wait APB with registered outputs.
*/
`timescale 1ns/1ps
`include "adcc_regs.vh"
module adcc_top_props (
    // APB
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    // Outputs watched
    input wire [2:0]  channel_sel,
    input wire        converter_power,
    input wire [4:0]  analog_pin_en,
    input wire        vref_pos_pin,
    input wire        vref_neg_pin,
    input wire        irq
);
    wire       acc  = psel && penable;
    wire       wfmt = acc && pwrite && paddr == `ADCC_OFF_FMT;
    reg        just_r;
    reg  [3:0] code_r;
    // Shadow of the format bits, kept apart from the design
    always @(posedge pclk or negedge presetn)
        if (!presetn) begin
            just_r <= 1'h0;
            code_r <= 4'h0;
        end else if (wfmt) begin
            just_r <= pwdata[7];
            code_r <= pwdata[3:0];
        end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_fmt_rd;
        acc && !pwrite && paddr == `ADCC_OFF_FMT |-> (prdata & 32'hFFFFFF30) == 32'h0;
    endproperty
    a_fmt_rd: assert property (p_fmt_rd) else $error("format read bits set");
    property p_just;
        acc && !pwrite && paddr == (just_r ? `ADCC_OFF_RESH : `ADCC_OFF_RESL)
        |-> (prdata & (just_r ? 32'hFC : 32'h3F)) == 32'h0;
    endproperty
    a_just: assert property (p_just) else $error("padding bits set");
    property p_pin_neg;
        vref_neg_pin |-> vref_pos_pin && !analog_pin_en[0] == 1'h0;
    endproperty
    a_pin_neg: assert property (p_pin_neg) else $error("lone neg ref");
    property p_pin_wr;
        wfmt |-> ##2 {vref_pos_pin, vref_neg_pin} ==
            {code_r inside {4'h1, 4'h3, 4'h5, 4'h8, 4'hA, [4'hB:4'hD], 4'hF},
             code_r inside {4'h8, 4'hB, 4'hC, 4'hD, 4'hF}};
    endproperty
    a_pin_wr: assert property (p_pin_wr) else $error("ref pins wrong");
    property p_chan;
        channel_sel <= 3'h4;
    endproperty
    a_chan: assert property (p_chan) else $error("channel out of range");
    property p_pwr;
        acc && pwrite && paddr == `ADCC_OFF_CONV
        |-> ##2 converter_power == $past(pwdata[0], 2);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power not enable");
    property p_rst;
        $rose(presetn) |-> analog_pin_en == 5'h1F && !vref_pos_pin;
    endproperty
    a_rst: assert property (p_rst) else $error("pins not reset");
    property p_irq_off;
        acc && pwrite && !pwdata[0] &&
        (paddr == `ADCC_OFF_IRQ_EN || paddr == `ADCC_OFF_GIE) |-> ##2 !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq unmasked");
endmodule

bind adcc_top adcc_top_props u_adcc_top_props (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .channel_sel,
    .converter_power, .analog_pin_en, .vref_pos_pin, .vref_neg_pin, .irq);

// ---- adcc_pin_model.sv ----
/*
 Analog pin model: five fixed input levels and the comparator.
 Assumes the trial code is steady for a bit period.
*/
`timescale 1ns/1ps
module adcc_pin_model #(
    parameter [49:0] LVLS = 50'h0
) (
    // Converter side
    input  wire [9:0] dac_code,
    input  wire [2:0] channel_sel,
    // Comparator
    output wire       cmp_above
);
    // Level sits half a step above its code, so either rounding fits
    assign cmp_above = LVLS[channel_sel * 10 +: 10] >= dac_code;
endmodule

// ---- adcc_top_tb_top.sv ----
/*
 Bench for adcc_top: pin code table, conversions, interrupt.
 Assumes zero wait APB and the pin model on the comparator.
*/
`timescale 1ns/1ps
`include "adcc_regs.vh"
module adcc_top_tb_top;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0;
    logic        penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, cmp_above, hold_connect, irq;
    logic        converter_power, vref_pos_pin, vref_neg_pin;
    logic [9:0]  dac_code;
    logic [2:0]  channel_sel;
    logic [4:0]  analog_pin_en;
    int          errors = 0, compares = 0, d0, d1;
    localparam logic [49:0] LVLS = {10'h001, 10'h155, 10'h200,
                                    10'h2A5, 10'h3FF};
    // Row: pin code, then {pos ref, neg ref, analog pins}
    logic [10:0] rows [16] = '{11'h01F, 11'h0D7, 11'h11F, 11'h1D7,
        11'h20B, 11'h2C3, 11'h300, 11'h380, 11'h473, 11'h49F, 11'h557,
        11'h5F3, 11'h673, 11'h6E3, 11'h701, 11'h7E1};

    adcc_top u_adcc_top (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .cmp_above,
        .dac_code, .channel_sel, .hold_connect, .converter_power,
        .analog_pin_en, .vref_pos_pin, .vref_neg_pin, .irq);
    adcc_pin_model #(.LVLS(LVLS)) u_adcc_pin_model (.dac_code,
        .channel_sel, .cmp_above);

    initial forever #20 pclk = ~pclk;

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask

    task wrap_up;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        r = prdata;
        chk("pslverr", 32'h0, pslverr);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // Configure, wait acquisition, start, poll, check result
    task conv(input logic [2:0] ch, input logic [7:0] fmt,
              input logic [1:0] cs, output int dur);
        logic [9:0] l;
        l = LVLS[ch * 10 +: 10];
        apb(1'h1, `ADCC_OFF_FMT, fmt, rd);
        apb(1'h1, `ADCC_OFF_CONV, {cs, ch, 3'h1}, rd);
        // Settle, charge and temperature terms, about 20 us
        repeat (500) @(posedge pclk);
        apb(1'h1, `ADCC_OFF_CONV, {cs, ch, 3'h5}, rd);
        dur = 0;
        do apb(1'h0, `ADCC_OFF_CONV, 32'h0, rd);
        while (rd[2] === 1'h1 && ++dur < 1000);
        chk("go_done", 32'h0, rd & 32'h4);
        apb(1'h0, `ADCC_OFF_IRQ_STAT, 32'h0, rd);
        chk("flag", 32'h1, rd);
        apb(1'h0, `ADCC_OFF_RESH, 32'h0, rd);
        chk("resh", fmt[7] ? l[9:8] : l[9:2], rd);
        apb(1'h0, `ADCC_OFF_RESL, 32'h0, rd);
        chk("resl", fmt[7] ? l[7:0] : {l[1:0], 6'h0}, rd);
    endtask

    initial begin
        #800000;
        errors++;
        wrap_up;
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, `ADCC_OFF_FMT, 32'h0, rd);
        chk("fmt_rst", 32'h0, rd);
        chk("pins_rst", 32'h1F, analog_pin_en);
        for (int i = 0; i < 16; i++) begin
            apb(1'h1, `ADCC_OFF_FMT, {i[1:0], 2'h3, rows[i][10:7]}, rd);
            apb(1'h0, `ADCC_OFF_FMT, 32'h0, rd);
            chk("fmt", {i[1:0], 2'h0, rows[i][10:7]}, rd);
            chk("pins", rows[i][6:0],
                {vref_pos_pin, vref_neg_pin, analog_pin_en});
        end
        apb(1'h1, `ADCC_OFF_IRQ_EN, 32'h1, rd);
        apb(1'h1, `ADCC_OFF_GIE, 32'h1, rd);
        conv(3'h1, 8'h80, 2'h0, d0);
        chk("irq", 32'h1, irq);
        apb(1'h1, `ADCC_OFF_IRQ_EN, 32'h0, rd);
        repeat (2) @(posedge pclk);
        chk("irq_mask", 32'h0, irq);
        apb(1'h0, `ADCC_OFF_IRQ_STAT, 32'h0, rd);
        chk("sticky", 32'h1, rd);
        apb(1'h1, `ADCC_OFF_IRQ_CLR, 32'h1, rd);
        apb(1'h0, `ADCC_OFF_IRQ_STAT, 32'h0, rd);
        chk("cleared", 32'h0, rd);
        conv(3'h4, 8'h40, 2'h0, d1);
        chk("halve", 32'h1, d1 > d0 + d0 / 2);
        conv(3'h0, 8'h80, 2'h0, d0);
        conv(3'h2, 8'h00, 2'h3, d1);
        chk("rc_clock", 32'h1, d1 > 2 * `ADCC_RC_CYC);
        chk("hold_gap", 32'h0, hold_connect);
        repeat (`ADCC_GAP_TAD * `ADCC_RC_CYC) @(posedge pclk);
        chk("hold_back", 32'h1, hold_connect);
        apb(1'h1, `ADCC_OFF_CONV, 32'h39, rd);
        repeat (2) @(posedge pclk);
        chk("chan_clamp", 32'h0, channel_sel);
        apb(1'h1, `ADCC_OFF_CONV, 32'h0, rd);
        apb(1'h1, `ADCC_OFF_CONV, 32'h4, rd);
        apb(1'h0, `ADCC_OFF_CONV, 32'h0, rd);
        chk("go_off", 32'h0, rd & 32'h5);
        chk("power", 32'h0, converter_power);
        apb(1'h1, 12'h100, 32'hFF, rd);
        apb(1'h0, 12'h100, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        // Reset in mid-run must drop a nonzero format setting
        apb(1'h1, `ADCC_OFF_FMT, 32'hCF, rd);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, `ADCC_OFF_FMT, 32'h0, rd);
        chk("fmt_rst2", 32'h0, rd);
        chk("pins_rst2", 32'h1F, analog_pin_en);
        wrap_up;
    end
endmodule
